// ### rtl/wwd_params.svh
`ifndef WWD_PARAMS_SVH
`define WWD_PARAMS_SVH
// ----------------------------------------
// register map, byte offsets on apb
// ----------------------------------------
`define WWD_AW 12
`define WWD_OFF_CON0 12'h000
`define WWD_OFF_CON1 12'h004
`define WWD_OFF_POWER_CONTROL_REG 12'h008
`define WWD_OFF_CNT 12'h00c
`define WWD_OFF_ISTAT 12'h010
`define WWD_OFF_ICLR 12'h014
`define WWD_OFF_IEN 12'h018
// ----------------------------------------
// field positions
// ----------------------------------------
`define WWD_SEN_BIT 0
`define WWD_PS_LSB 1
`define WWD_PS_MSB 5
`define WWD_WIN_LSB 0
`define WWD_WIN_MSB 2
`define WWD_CS_LSB 4
`define WWD_CS_MSB 6
`define WWD_WV_BIT 0
`define WWD_RW_BIT 1
`define WWD_TO_BIT 2
`define WWD_PD_BIT 3
`define WWD_IRQ_BITE 0
`define WWD_IRQ_VIOL 1
`define WWD_IRQ_WAKE 2
`define WWD_IRQ_W 3
// ----------------------------------------
// reset values, limits and timing
// ----------------------------------------
`define WWD_PS_RST 5'h0b
`define WWD_PS_MAX 5'h12
`define WWD_WIN_OPEN 3'h7
`define WWD_CS_MF 3'h1
`define WWD_CS_REG 3'h7
`define WWD_CNT_W 23
`define WWD_TICK_LOG 5
`define WWD_CLK_HZ 50000000
`define WWD_LF_HZ 31000
`define WWD_MF_HZ 31250
`endif

// ### rtl/wwd_pkg.sv
`default_nettype none
`include "wwd_params.svh"
package wwd_pkg;
   // enable modes of the configuration field
   typedef enum logic [1:0] {
      WWD_EN_OFF = 2'b00,
      WWD_EN_SW = 2'b01,
      WWD_EN_AWAKE = 2'b10,
      WWD_EN_ON = 2'b11
   } wwd_en_mode_t;
   // watchdog count word
   typedef logic [`WWD_CNT_W-1:0] wwd_cnt_t;
endpackage
`default_nettype wire

// ### rtl/wwd_tick.sv
`default_nettype none
`include "wwd_params.svh"
module wwd_tick #(
   parameter int LF_DIV = `WWD_CLK_HZ / `WWD_LF_HZ,
   parameter int MF_DIV = `WWD_CLK_HZ / `WWD_MF_HZ
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   wwd_tick_if.gen tick_bus
);
   import wwd_pkg::*;
   // ----------------------------------------
   // oscillator emulation divider
   // ----------------------------------------
   localparam int DW = $clog2(LF_DIV > MF_DIV ? LF_DIV : MF_DIV) + 1;
   if (LF_DIV < 2 || MF_DIV < 2) begin : g_bad_div
      $error("wwd_tick: dividers must be at least 2");
   end
   logic [DW-1:0] div; // cycles since last tick
   logic sel_q; // previous source choice
   wire [DW-1:0] div_top = tick_bus.mf_sel ? DW'(MF_DIV - 1) : DW'(LF_DIV - 1);
   wire div_end = (div >= div_top);
   wire sel_chg = (sel_q != tick_bus.mf_sel);
   // restart the period when the source changes
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div <= '0;
         sel_q <= 1'b0;
         tick_bus.tick <= 1'b0;
      end else begin
         sel_q <= tick_bus.mf_sel;
         tick_bus.tick <= div_end && !sel_chg;
         div <= (div_end || sel_chg) ? '0 : div + 1'b1;
      end
   end
   // ticks never come back to back
   a_tick_spacing: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      tick_bus.tick |=> !tick_bus.tick) else $error("tick pulses adjacent");
endmodule
`default_nettype wire

// ### rtl/wwd_tick_if.sv
`default_nettype none
interface wwd_tick_if;
   logic mf_sel; // high selects the mid oscillator
   logic tick; // one-cycle time base pulse
   modport ctl (output mf_sel, input tick);
   modport gen (input mf_sel, output tick);
endinterface
`default_nettype wire

// ### rtl/wwd_top.sv
// What this block does
// - prescale field picks 1 ms to 256 s
// - two second period after any reset
// - kick outside window causes watchdog reset
// - window from config, or register when 111
// - violation resets and clears violation flag
// - count cleared by reset, kick, disable, con0 or con1 writes
// - windowed kick needs prior control read arming
// - count cleared entering and leaving sleep
// - count held zero while start-up timer runs
// - sleep timeout wakes, updates status, no reset
// - time base from low or mid oscillator
// - enable field 11 always active
// - enable field 10 off during sleep
// - enable field 01 follows software enable
`default_nettype none
`include "wwd_params.svh"
module wwd_top #(
   parameter int LF_DIV = `WWD_CLK_HZ / `WWD_LF_HZ,
   parameter int MF_DIV = `WWD_CLK_HZ / `WWD_MF_HZ
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic [`WWD_AW-1:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire wwd_pkg::wwd_en_mode_t config_enable_field_i,
   input wire logic [2:0] config_window_size_i,
   input wire logic [2:0] config_clock_select_field_i,
   input wire logic kick_instruction_i,
   input wire logic sleep_i,
   input wire logic ost_run_i,
   output logic wdt_rst_o,
   output logic wake_o,
   output logic irq_o
);
   import wwd_pkg::*;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // terminal count for a prescale value
   function automatic wwd_cnt_t wwd_limit(input logic [4:0] ps);
      wwd_cnt_t one;
      one = wwd_cnt_t'(1);
      return (one << (ps + 5'(`WWD_TICK_LOG))) - one;
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic software_enable_bit; // software enable bit
   logic [4:0] ps; // timeout prescale field
   logic [2:0] win_reg; // register window size
   logic [2:0] cs_reg; // register clock select
   logic wv_flag; // window violation flag, low after one
   logic rw_flag; // watchdog reset flag, low after any expiry
   logic to_bit; // timeout status, low after timeout
   logic pd_bit; // power-down status, low after sleep
   logic [`WWD_IRQ_W-1:0] irq_stat; // sticky events
   logic [`WWD_IRQ_W-1:0] irq_en; // event enables
   wwd_cnt_t cnt; // watchdog count
   logic armed; // control read seen since last kick
   logic sleep_q; // sleep level one cycle ago
   logic ps_written; // helper: prescale written since reset

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   wire setup = psel_i && !penable_i;
   wire access = psel_i && penable_i;
   wire wr = access && pwrite_i;
   wire rd = access && !pwrite_i;
   wire hit_con0 = (paddr_i == `WWD_OFF_CON0);
   wire hit_con1 = (paddr_i == `WWD_OFF_CON1);
   wire hit_power_control_reg = (paddr_i == `WWD_OFF_POWER_CONTROL_REG);
   wire hit_cnt = (paddr_i == `WWD_OFF_CNT);
   wire hit_ist = (paddr_i == `WWD_OFF_ISTAT);
   wire hit_icl = (paddr_i == `WWD_OFF_ICLR);
   wire hit_ien = (paddr_i == `WWD_OFF_IEN);
   wire mapped = hit_con0 || hit_con1 || hit_power_control_reg || hit_cnt ||
                 hit_ist || hit_icl || hit_ien;
   wire wr_con0 = wr && hit_con0;
   wire wr_con1 = wr && hit_con1;
   wire wr_power_control_reg = wr && hit_power_control_reg;
   wire wr_icl = wr && hit_icl;
   wire wr_ien = wr && hit_ien;
   wire rd_con0 = rd && hit_con0;

   // zero wait states: every access ends in its first access cycle
   assign pready_o = 1'b1;

   // read data mux, captured in the setup cycle
   wire [31:0] con0_rd = {26'h0, ps, software_enable_bit};
   wire [31:0] con1_rd = {25'h0, cs_reg, 1'b0, win_reg};
   wire [31:0] power_control_reg_rd = {28'h0, pd_bit, to_bit, rw_flag, wv_flag};
   wire [31:0] next_rdata =
      hit_con0 ? con0_rd :
      hit_con1 ? con1_rd :
      hit_power_control_reg ? power_control_reg_rd :
      hit_cnt ? 32'(cnt) :
      hit_ist ? 32'(irq_stat) :
      hit_ien ? 32'(irq_en) : 32'h0;

   // ----------------------------------------
   // mode, window and time base selection
   // ----------------------------------------
   // enable mode table
   logic active;
   always_comb begin
      case (config_enable_field_i)
         WWD_EN_ON: active = 1'b1;
         WWD_EN_AWAKE: active = !sleep_i;
         WWD_EN_SW: active = software_enable_bit;
         WWD_EN_OFF: active = 1'b0;
         default: active = 1'b0;
      endcase
   end

   // window size source
   wire [2:0] eff_win = (config_window_size_i == `WWD_CS_REG) ?
                        win_reg : config_window_size_i;
   wire windowed = (eff_win != `WWD_WIN_OPEN);
   // out-of-range prescale codes saturate at the longest period
   wire [4:0] ps_eff = (ps > `WWD_PS_MAX) ? `WWD_PS_MAX : ps;
   wire wwd_cnt_t limit = wwd_limit(ps_eff);
   // eighth of the period the count is in
   wire [2:0] win_pos = 3'(cnt >> (ps_eff + 5'(`WWD_TICK_LOG - 3)));
   wire in_window = (win_pos >= (`WWD_WIN_OPEN - eff_win));

   // time base source
   wire [2:0] eff_cs = (config_clock_select_field_i == `WWD_CS_REG) ?
                       cs_reg : config_clock_select_field_i;
   wwd_tick_if tb_if ();
   assign tb_if.mf_sel = (eff_cs == `WWD_CS_MF);
   wwd_tick #(
      .LF_DIV(LF_DIV),
      .MF_DIV(MF_DIV)
   ) u_tick (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .tick_bus(tb_if.gen)
   );
   wire tick = tb_if.tick;

   // ----------------------------------------
   // watchdog events
   // ----------------------------------------
   wire kick = kick_instruction_i && active;
   // early kick or kick without arming
   wire violation = kick && windowed && (!armed || !in_window);
   wire valid_kick = kick && !violation;
   wire expire = active && tick && (cnt == limit);
   wire bite = expire && !sleep_i;
   wire wake = expire && sleep_i;
   wire sleep_chg = (sleep_i != sleep_q);
   wire reg_wr = wr_con0 || wr_con1;
   // every cause that empties the count
   wire cnt_clr = !active || ost_run_i || sleep_chg || reg_wr ||
                  valid_kick || violation || expire;
   wire [`WWD_IRQ_W-1:0] irq_ev = {wake, violation, bite};

   // ----------------------------------------
   // apb response
   // ----------------------------------------
   // read data and error decided at setup, shown in access
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prdata_o <= 32'h0;
         pslverr_o <= 1'b0;
      end else if (setup) begin
         prdata_o <= pwrite_i ? 32'h0 : next_rdata;
         pslverr_o <= !mapped;
      end
   end

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   // software enable and prescale
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         software_enable_bit <= 1'b0;
         ps <= `WWD_PS_RST;
      end else if (wr_con0) begin
         software_enable_bit <= pwdata_i[`WWD_SEN_BIT];
         ps <= pwdata_i[`WWD_PS_MSB:`WWD_PS_LSB];
      end
   end

   // window and clock select
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         win_reg <= `WWD_WIN_OPEN;
         cs_reg <= 3'h0;
      end else if (wr_con1) begin
         win_reg <= pwdata_i[`WWD_WIN_MSB:`WWD_WIN_LSB];
         cs_reg <= pwdata_i[`WWD_CS_MSB:`WWD_CS_LSB];
      end
   end

   // helper for the default-period check
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ps_written <= 1'b0;
      end else if (wr_con0) begin
         ps_written <= 1'b1;
      end
   end

   // ----------------------------------------
   // power control flags
   // ----------------------------------------
   // hardware events win over a software write in the same cycle
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wv_flag <= 1'b1;
         rw_flag <= 1'b1;
         to_bit <= 1'b1;
         pd_bit <= 1'b1;
      end else begin
         // violation flag: cleared by a violation reset
         if (violation) begin
            wv_flag <= 1'b0;
         end else if (wr_power_control_reg) begin
            wv_flag <= pwdata_i[`WWD_WV_BIT];
         end
         // reset flag: cleared by any expiry
         if (expire) begin
            rw_flag <= 1'b0;
         end else if (wr_power_control_reg) begin
            rw_flag <= pwdata_i[`WWD_RW_BIT];
         end
         // timeout status: low on expiry, high on a good kick
         if (expire) begin
            to_bit <= 1'b0;
         end else if (valid_kick) begin
            to_bit <= 1'b1;
         end else if (wr_power_control_reg) begin
            to_bit <= pwdata_i[`WWD_TO_BIT];
         end
         // power-down status: low on sleep entry or sleep expiry
         if ((sleep_i && !sleep_q) || wake) begin
            pd_bit <= 1'b0;
         end else if (valid_kick) begin
            pd_bit <= 1'b1;
         end else if (wr_power_control_reg) begin
            pd_bit <= pwdata_i[`WWD_PD_BIT];
         end
      end
   end

   // ----------------------------------------
   // interrupt status and enable
   // ----------------------------------------
   // new events win over a clear written in the same cycle
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_stat <= '0;
         irq_en <= '0;
      end else begin
         irq_stat <= (irq_stat & ~(wr_icl ? pwdata_i[`WWD_IRQ_W-1:0] : '0)) | irq_ev;
         if (wr_ien) begin
            irq_en <= pwdata_i[`WWD_IRQ_W-1:0];
         end
      end
   end
   assign irq_o = |(irq_stat & irq_en);

   // ----------------------------------------
   // watchdog count and outputs
   // ----------------------------------------
   // count advances one step per time base tick
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt <= '0;
         sleep_q <= 1'b0;
      end else begin
         sleep_q <= sleep_i;
         if (cnt_clr) begin
            cnt <= '0;
         end else if (tick) begin
            cnt <= cnt + 1'b1;
         end
      end
   end

   // arming: a control read opens the next kick
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         armed <= 1'b0;
      end else if (kick) begin
         armed <= 1'b0;
      end else if (rd_con0) begin
         armed <= 1'b1;
      end
   end

   // device reset and wake pulses
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wdt_rst_o <= 1'b0;
         wake_o <= 1'b0;
      end else begin
         wdt_rst_o <= bite || violation;
         wake_o <= wake;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_default_period: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      !ps_written |-> limit == wwd_limit(`WWD_PS_RST)) else $error("bad default period");
   a_prescale_range: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      wr_con0 |=> ps_eff <= `WWD_PS_MAX) else $error("prescale out of range");
   a_early_kick: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (kick && windowed && !in_window) |=> wdt_rst_o && cnt == '0)
      else $error("early kick not punished");
   a_window_source: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (config_window_size_i != `WWD_CS_REG && kick && in_window && armed)
      |=> !wdt_rst_o || $past(bite)) else $error("window source wrong");
   a_violation_flag: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      violation |=> !wv_flag && wdt_rst_o) else $error("violation flag kept");
   a_count_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (valid_kick || reg_wr || ost_run_i) |=> cnt == '0) else $error("count not cleared");
   a_arm_needed: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (kick && windowed && !armed) |=> wdt_rst_o ##1 !armed)
      else $error("unarmed kick accepted");
   a_sleep_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (sleep_i != $past(sleep_i)) |=> cnt == '0) else $error("sleep edge kept count");
   a_ost_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ost_run_i [*2] |-> cnt == '0 && !wdt_rst_o)
      else $error("count ran during start-up");
   a_sleep_wake: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (expire && sleep_i) |=> wake_o && !wdt_rst_o && !to_bit && !pd_bit)
      else $error("sleep expiry mishandled");
   a_awake_bite: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (active && !sleep_i && tick && cnt == limit && !kick_instruction_i)
      |=> wdt_rst_o && !rw_flag) else $error("missed timeout reset");
   a_off_mode: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      config_enable_field_i == WWD_EN_OFF |=> cnt == '0 && !wdt_rst_o && !wake_o)
      else $error("disabled watchdog acted");
   a_off_in_sleep: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (config_enable_field_i == WWD_EN_AWAKE && sleep_i) |=> cnt == '0 && !wake_o)
      else $error("watchdog ran in sleep");
   a_always_on: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (config_enable_field_i == WWD_EN_ON && tick && !cnt_clr) |=> cnt == $past(cnt) + 1'b1)
      else $error("always-on watchdog stalled");
   a_sw_enable: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (config_enable_field_i == WWD_EN_SW && !software_enable_bit) |=> cnt == '0 && !wdt_rst_o)
      else $error("software disable ignored");
endmodule
`default_nettype wire

// ### verif/wwd_top_bench.sv
`default_nettype none
`include "wwd_params.svh"
module wwd_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import wwd_pkg::*;
   // ----------------------------------------
   // bench settings and signals
   // ----------------------------------------
   localparam int LF = 2; // core cycles per low oscillator tick
   localparam int MF = 3; // core cycles per mid oscillator tick
   logic clk; // core clock
   logic rst_n; // active low reset
   logic [11:0] paddr;
   logic psel;
   logic penable;
   logic pwrite;
   logic [31:0] pwdata;
   wire logic [31:0] prdata;
   wire logic pready;
   wire logic pslverr;
   wwd_en_mode_t cfg_en; // enable mode pins
   logic [2:0] cfg_win; // window code pins
   logic [2:0] cfg_cs; // clock select pins
   logic kick; // clear instruction pulse
   logic sleep; // sleep level
   logic ost; // start-up timer running
   wire logic wdt_rst;
   wire logic wake;
   wire logic irq;
   logic [31:0] rdata; // last read data
   logic rerr; // last error flag
   int bad_count = 0;
   int cmp_count = 0;
   int cycles = 0; // run length in cycles
   int n_rst = 0; // reset pulses seen
   int n_wake = 0; // wake pulses seen
   int r0; // pulse count snapshot
   // ----------------------------------------
   // design under test
   // ----------------------------------------
   wwd_top #(.LF_DIV(LF), .MF_DIV(MF)) u_wwd_top (
      .core_clk_i(clk), .rst_n_i(rst_n), .paddr_i(paddr), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .config_enable_field_i(cfg_en),
      .config_window_size_i(cfg_win), .config_clock_select_field_i(cfg_cs),
      .kick_instruction_i(kick), .sleep_i(sleep), .ost_run_i(ost),
      .wdt_rst_o(wdt_rst), .wake_o(wake), .irq_o(irq)
   );
   // ----------------------------------------
   // clock, pulse counters and run limit
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // counts output pulses and cuts a hang short
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (wdt_rst === 1'b1) n_rst <= n_rst + 1;
      if (wake === 1'b1) n_wake <= n_wake + 1;
      if (cycles == 20000) begin
         bad_count = bad_count + 1;
         $display("BAD %0t run limit reached", $time);
         summarize();
      end
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   // compares one value and counts it
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   // one apb transfer, setup then access until pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      chk(rdata, exp, what);
   endtask
   // one clear instruction, a single cycle wide
   task automatic do_kick();
      @(posedge clk);
      kick <= 1'b1;
      @(posedge clk);
      kick <= 1'b0;
   endtask
   // waits for a reset or wake pulse and checks the delay
   task automatic expiry(input bit on_wake, input int lo, input int hi, input string what);
      int n;
      n = 0;
      while ((on_wake ? wake : wdt_rst) !== 1'b1 && n < 600) begin
         @(posedge clk);
         n++;
      end
      chk(32'(n >= lo && n <= hi), 32'h1, what);
   endtask
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
   endtask
   // prints the counts and the verdict, then stops
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial begin
      rst_n = 1'b0;
      {psel, penable, pwrite, kick, sleep, ost} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      cfg_en = WWD_EN_OFF;
      cfg_win = 3'h7;
      cfg_cs = 3'h0;
      do_reset();
      // reset values and an unmapped place
      rd(`WWD_OFF_CON0, 32'h16, "con0 after reset");
      rd(`WWD_OFF_CON1, 32'h07, "con1 after reset");
      rd(`WWD_OFF_POWER_CONTROL_REG, 32'h0f, "power_control_reg after reset");
      rd(`WWD_OFF_CNT, 32'h0, "count after reset");
      apb(1'b0, 12'h020, 32'h0);
      chk(rerr, 1'b1, "unmapped error");
      $display("test reset values done");
      // awake expiry for two prescales and both time bases
      cfg_en <= WWD_EN_AWAKE;
      wr(`WWD_OFF_CON0, 32'h0);
      expiry(0, 32 * LF - 8, 32 * LF + 8, "ps0 low osc period");
      rd(`WWD_OFF_POWER_CONTROL_REG, 32'h09, "flags after expiry");
      rd(`WWD_OFF_ISTAT, 32'h1, "expiry status");
      wr(`WWD_OFF_CON0, 32'h2);
      expiry(0, 64 * LF - 8, 64 * LF + 8, "ps1 period");
      cfg_cs <= 3'h1;
      wr(`WWD_OFF_CON0, 32'h0);
      expiry(0, 32 * MF - 8, 32 * MF + 8, "mid osc period");
      cfg_cs <= 3'h7;
      wr(`WWD_OFF_CON1, 32'h17);
      expiry(0, 32 * MF - 8, 32 * MF + 8, "mid osc from con1");
      cfg_cs <= 3'h0;
      wr(`WWD_OFF_CON1, 32'h07);
      $display("test expiry done");
      // interrupt masked, enabled and cleared
      cfg_en <= WWD_EN_OFF;
      wr(`WWD_OFF_IEN, 32'h0);
      @(posedge clk);
      chk(irq, 1'b0, "irq masked");
      wr(`WWD_OFF_IEN, 32'h1);
      @(posedge clk);
      chk(irq, 1'b1, "irq enabled");
      wr(`WWD_OFF_ICLR, 32'h7);
      @(posedge clk);
      chk(irq, 1'b0, "irq cleared");
      $display("test interrupt done");
      // enable modes off and software
      r0 = n_rst;
      wr(`WWD_OFF_CON0, 32'h1);
      repeat (200) @(posedge clk);
      chk(n_rst - r0, 0, "mode off stays quiet");
      cfg_en <= WWD_EN_SW;
      wr(`WWD_OFF_CON0, 32'h1);
      expiry(0, 32 * LF - 8, 32 * LF + 8, "software enabled");
      wr(`WWD_OFF_CON0, 32'h0);
      r0 = n_rst;
      repeat (200) @(posedge clk);
      chk(n_rst - r0, 0, "software disabled");
      $display("test enable modes done");
      // kicks and writes clear the count
      cfg_en <= WWD_EN_AWAKE;
      wr(`WWD_OFF_CON0, 32'h0);
      r0 = n_rst;
      repeat (6) begin
         repeat (40) @(posedge clk);
         do_kick();
      end
      chk(n_rst - r0, 0, "kicks keep alive");
      apb(1'b0, `WWD_OFF_CNT, 32'h0);
      chk(rerr, 1'b0, "count readable");
      chk(32'(rdata < 4), 32'h1, "count small after kick");
      repeat (40) @(posedge clk);
      wr(`WWD_OFF_CON1, 32'h07);
      apb(1'b0, `WWD_OFF_CNT, 32'h0);
      chk(32'(rdata < 4), 32'h1, "count small after write");
      $display("test clearing done");
      // windowed mode violations and a valid kick
      cfg_win <= 3'h0;
      wr(`WWD_OFF_CON0, 32'h0);
      do_kick();
      expiry(0, 0, 3, "kick without arming");
      apb(1'b0, `WWD_OFF_POWER_CONTROL_REG, 32'h0);
      chk(rdata & 32'h1, 32'h0, "violation flag cleared");
      wr(`WWD_OFF_POWER_CONTROL_REG, 32'hf);
      rd(`WWD_OFF_POWER_CONTROL_REG, 32'h0f, "flag set by firmware");
      apb(1'b0, `WWD_OFF_CON0, 32'h0);
      do_kick();
      expiry(0, 0, 3, "armed kick too early");
      cfg_win <= 3'h4;
      wr(`WWD_OFF_CON0, 32'h0);
      repeat (40) @(posedge clk);
      apb(1'b0, `WWD_OFF_CON0, 32'h0);
      r0 = n_rst;
      do_kick();
      repeat (3) @(posedge clk);
      chk(n_rst - r0, 0, "armed kick in window");
      cfg_win <= 3'h7;
      wr(`WWD_OFF_CON1, 32'h00);
      do_kick();
      expiry(0, 0, 3, "window from con1");
      wr(`WWD_OFF_CON1, 32'h07);
      r0 = n_rst;
      do_kick();
      repeat (3) @(posedge clk);
      chk(n_rst - r0, 0, "con1 window open");
      $display("test window done");
      // sleep: wake on expiry, count cleared on entry, off in sleep
      cfg_en <= WWD_EN_ON;
      wr(`WWD_OFF_POWER_CONTROL_REG, 32'hf);
      wr(`WWD_OFF_CON0, 32'h0);
      repeat (40) @(posedge clk);
      r0 = n_rst;
      sleep <= 1'b1;
      expiry(1, 32 * LF - 8, 32 * LF + 8, "wake from sleep");
      chk(n_rst - r0, 0, "no reset in sleep");
      rd(`WWD_OFF_POWER_CONTROL_REG, 32'h01, "flags after wake");
      apb(1'b0, `WWD_OFF_ISTAT, 32'h0);
      chk(rdata & 32'h4, 32'h4, "wake status");
      sleep <= 1'b0;
      cfg_en <= WWD_EN_AWAKE;
      @(posedge clk);
      sleep <= 1'b1;
      r0 = n_rst + n_wake;
      repeat (200) @(posedge clk);
      chk(n_rst + n_wake - r0, 0, "awake mode off in sleep");
      sleep <= 1'b0;
      $display("test sleep done");
      // start-up timer holds the count
      cfg_en <= WWD_EN_ON;
      ost <= 1'b1;
      r0 = n_rst;
      repeat (200) @(posedge clk);
      rd(`WWD_OFF_CNT, 32'h0, "count held by start-up");
      chk(n_rst - r0, 0, "no expiry during start-up");
      ost <= 1'b0;
      // second reset restores the default period
      wr(`WWD_OFF_CON0, 32'h3f);
      do_reset();
      rd(`WWD_OFF_CON0, 32'h16, "con0 after second reset");
      $display("test start-up and reset done");
      summarize();
   end
endmodule
`default_nettype wire
